// *** verilog/fei_pkg.sv ***
// Constants, types and the register decoder for the falling-edge event enable block.
// Assumes a single 250 MHz core clock and an AXI4-Lite master with 32-bit data.
// What this block does
// - An id-ground high-to-low change raises an event when enable bit 4 is set.
// - The id-ground falling event is suppressed while the id pull-up control is 0 and for 50 ms after it is set.
// - A session-end high-to-low change raises an event when enable bit 3 is set.
// - A session-valid high-to-low change raises an event when enable bit 2 is set.
// - A vbus-ok high-to-low change raises an event when enable bit 1 is set.
// - The host-disconnect falling event, enabled by bit 0, fires only when both pull-down controls are 1.
// - After reset the five enable bits read 1, and reserved bits 7 to 5 read 0 and ignore writes.
// - A write to the set alias sets every enable bit written as one and leaves the others alone.
// - A read of the set alias returns the enable register contents.
// - A write to the clear alias clears every enable bit written as one; a read returns the enable contents.
package fei_pkg;

  localparam int SIG_W = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  typedef logic [SIG_W-1:0] fei_sig_type;

  // Bit positions shared by the enable register, status inputs and event outputs.
  localparam int SIG_HOST_DISC = 0;
  localparam int SIG_VBUS_OK = 1;
  localparam int SIG_SESS_VALID = 2;
  localparam int SIG_SESS_END = 3;
  localparam int SIG_ID_GROUND = 4;

  localparam fei_sig_type EN_RESET = 5'h1f;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_EN = 8'h10;
  localparam logic [7:0] IDX_EN_SET = 8'h11;
  localparam logic [7:0] IDX_EN_CLR = 8'h12;
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_STAT = 8'h21;

  localparam logic [ADDR_W-1:0] ADDR_EN = {IDX_EN[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EN_SET = {IDX_EN_SET[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EN_CLR = {IDX_EN_CLR[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STAT = {IDX_STAT[5:0], 2'h0};

  localparam int STAT_MASK_BIT = 8;
  localparam int STAT_HOST_BIT = 9;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Id-ground settling time after the pull-up is switched on.
  localparam int CLK_MHZ = 250;
  localparam int ID_SETTLE_MS = 50;
  localparam int ID_SETTLE_CYCLES = ID_SETTLE_MS * 1000 * CLK_MHZ;

  typedef struct packed {
    logic dminus_pulldown_ctrl;
    logic dplus_pulldown_ctrl;
    logic id_pullup_ctrl;
  } fei_ctrl_type;

  localparam fei_ctrl_type CTRL_RESET = 3'h0;

  typedef enum logic [5:0] {
    SEL_NONE = 6'h01,
    SEL_EN = 6'h02,
    SEL_EN_SET = 6'h04,
    SEL_EN_CLR = 6'h08,
    SEL_CTRL = 6'h10,
    SEL_STAT = 6'h20
  } fei_sel_type;

  typedef enum logic [1:0] {
    WP_COLLECT = 2'h1,
    WP_RESP = 2'h2
  } fei_wphase_type;

  function automatic fei_sel_type fei_decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] word;
    word = {addr[ADDR_W-1:2], 2'h0};
    if (word == ADDR_EN) begin
      fei_decode = SEL_EN;
    end else if (word == ADDR_EN_SET) begin
      fei_decode = SEL_EN_SET;
    end else if (word == ADDR_EN_CLR) begin
      fei_decode = SEL_EN_CLR;
    end else if (word == ADDR_CTRL) begin
      fei_decode = SEL_CTRL;
    end else if (word == ADDR_STAT) begin
      fei_decode = SEL_STAT;
    end else begin
      fei_decode = SEL_NONE;
    end
  endfunction : fei_decode

endpackage : fei_pkg

// *** verilog/fei_fall_detect.sv ***
// Two-stage synchroniser and falling-edge detector for a group of slow status pins.
// Assumes the inputs are asynchronous to core_clk and change far slower than it.
`timescale 1ns/1ns
module fei_fall_detect #(
  parameter int WIDTH = 5
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] fall
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("fei_fall_detect: WIDTH must be at least 1.");
    end
  endgenerate

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] fall;
  } fd_state_type;

  fd_state_type s;
  fd_state_type next_s;

  always_comb begin
    next_s = s;
    next_s.meta = async_in;
    next_s.sync = s.meta;
    next_s.prev = s.sync;
    next_s.fall = s.prev & ~s.sync;
    if (srst) begin
      next_s = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    s <= next_s;
  end

  assign level = s.sync;
  assign fall = s.fall;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_fall_one_pulse: assert property (
    (s.prev & ~s.sync) != '0 |=> s.fall == $past(s.prev & ~s.sync) ##1 (s.fall & $past(s.fall)) == '0)
    else $error("Falling-edge pulse wrong or longer than one cycle.");

endmodule : fei_fall_detect

// *** verilog/fei_core.sv ***
// Falling-edge event enable register with set and clear aliases, and the event gating it steers.
// Assumes an AXI4-Lite master on core_clk and asynchronous PHY status pins.
`timescale 1ns/1ns
module fei_core #(
  parameter int ID_SETTLE_CYCLES = fei_pkg::ID_SETTLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [fei_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [fei_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [fei_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [fei_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic [fei_pkg::SIG_W-1:0] phy_status,
  output fei_pkg::fei_ctrl_type phy_ctrl,
  output logic [fei_pkg::SIG_W-1:0] fall_event,
  output logic fall_event_any
);

  localparam int CNT_W = $clog2(ID_SETTLE_CYCLES + 1);

  generate
    if (ID_SETTLE_CYCLES < 1) begin : g_bad_settle
      $error("fei_core: ID_SETTLE_CYCLES must be at least 1.");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    fei_pkg::fei_sig_type en;
    fei_pkg::fei_ctrl_type ctrl;
    logic [CNT_W-1:0] settle;
    fei_pkg::fei_wphase_type wph;
    logic aw_have;
    logic w_have;
    logic [fei_pkg::ADDR_W-1:0] awaddr;
    logic [fei_pkg::SIG_W-1:0] wdata;
    logic wstrb0;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [fei_pkg::DATA_W-1:0] rdata;
    fei_pkg::fei_sig_type event_q;
    logic event_any;
  } fei_core_state_type;

  localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(ID_SETTLE_CYCLES);

  fei_core_state_type s;
  fei_core_state_type next_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Status pin synchronisation and edge gating.

  fei_pkg::fei_sig_type level;
  fei_pkg::fei_sig_type fall;
  fei_pkg::fei_sig_type allow;
  fei_pkg::fei_sig_type gated;
  logic id_mask;
  logic host_mode;

  fei_fall_detect #(
    .WIDTH(fei_pkg::SIG_W)
  ) u_fall_detect (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(phy_status),
    .level(level),
    .fall(fall)
  );

  // Id-ground stays masked until the pull-up has been on for the settling time.
  assign id_mask = !s.ctrl.id_pullup_ctrl || (s.settle != '0);
  assign host_mode = s.ctrl.dplus_pulldown_ctrl && s.ctrl.dminus_pulldown_ctrl;

  genvar gi;
  generate
    for (gi = 0; gi < fei_pkg::SIG_W; gi++) begin : g_gate
      if (gi == fei_pkg::SIG_ID_GROUND) begin : g_id
        assign allow[gi] = !id_mask;
      end else if (gi == fei_pkg::SIG_HOST_DISC) begin : g_host
        assign allow[gi] = host_mode;
      end else begin : g_plain
        assign allow[gi] = 1'b1;
      end
      assign gated[gi] = fall[gi] & s.en[gi] & allow[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshakes.

  logic aw_take;
  logic w_take;
  logic aw_in;
  logic w_in;
  logic wr_commit;
  logic [fei_pkg::ADDR_W-1:0] wr_addr;
  logic [fei_pkg::SIG_W-1:0] wr_data;
  logic wr_strb0;
  fei_pkg::fei_sel_type wr_sel;
  fei_pkg::fei_sel_type rd_sel;
  logic rd_take;

  assign s_axi_awready = (s.wph == fei_pkg::WP_COLLECT) && !s.aw_have;
  assign s_axi_wready = (s.wph == fei_pkg::WP_COLLECT) && !s.w_have;
  assign s_axi_bvalid = (s.wph == fei_pkg::WP_RESP);
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign aw_in = s.aw_have || aw_take;
  assign w_in = s.w_have || w_take;
  assign wr_commit = (s.wph == fei_pkg::WP_COLLECT) && aw_in && w_in;
  assign wr_addr = s.aw_have ? s.awaddr : s_axi_awaddr;
  assign wr_data = s.w_have ? s.wdata : s_axi_wdata[fei_pkg::SIG_W-1:0];
  assign wr_strb0 = s.w_have ? s.wstrb0 : s_axi_wstrb[0];
  assign wr_sel = fei_pkg::fei_decode(wr_addr);
  assign rd_sel = fei_pkg::fei_decode(s_axi_araddr);
  assign rd_take = s_axi_arvalid && s_axi_arready;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_s = s;

    // Settling timer reloads while the pull-up is off and runs down once it is on.
    if (!s.ctrl.id_pullup_ctrl) begin
      next_s.settle = SETTLE_LOAD;
    end else if (s.settle != '0) begin
      next_s.settle = s.settle - 1'b1;
    end

    next_s.event_q = gated;
    next_s.event_any = |gated;

    if (aw_take) begin
      next_s.aw_have = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (w_take) begin
      next_s.w_have = 1'b1;
      next_s.wdata = s_axi_wdata[fei_pkg::SIG_W-1:0];
      next_s.wstrb0 = s_axi_wstrb[0];
    end

    if (wr_commit) begin
      next_s.wph = fei_pkg::WP_RESP;
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.bresp = fei_pkg::RESP_OKAY;
      if (wr_sel == fei_pkg::SEL_EN) begin
        if (wr_strb0) begin
          next_s.en = wr_data;
        end
      end else if (wr_sel == fei_pkg::SEL_EN_SET) begin
        if (wr_strb0) begin
          next_s.en = s.en | wr_data;
        end
      end else if (wr_sel == fei_pkg::SEL_EN_CLR) begin
        if (wr_strb0) begin
          next_s.en = s.en & ~wr_data;
        end
      end else if (wr_sel == fei_pkg::SEL_CTRL) begin
        if (wr_strb0) begin
          next_s.ctrl = fei_pkg::fei_ctrl_type'(wr_data[2:0]);
        end
      end else begin
        next_s.bresp = fei_pkg::RESP_SLVERR;
      end
    end else if (s.wph == fei_pkg::WP_RESP && s_axi_bready) begin
      next_s.wph = fei_pkg::WP_COLLECT;
    end

    if (rd_take) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = fei_pkg::RESP_OKAY;
      next_s.rdata = '0;
      if (rd_sel == fei_pkg::SEL_EN || rd_sel == fei_pkg::SEL_EN_SET || rd_sel == fei_pkg::SEL_EN_CLR) begin
        next_s.rdata[fei_pkg::SIG_W-1:0] = s.en;
      end else if (rd_sel == fei_pkg::SEL_CTRL) begin
        next_s.rdata[2:0] = s.ctrl;
      end else if (rd_sel == fei_pkg::SEL_STAT) begin
        next_s.rdata[fei_pkg::SIG_W-1:0] = level;
        next_s.rdata[fei_pkg::STAT_MASK_BIT] = id_mask;
        next_s.rdata[fei_pkg::STAT_HOST_BIT] = host_mode;
      end else begin
        next_s.rresp = fei_pkg::RESP_SLVERR;
      end
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    if (srst) begin
      next_s = '0;
      next_s.en = fei_pkg::EN_RESET;
      next_s.ctrl = fei_pkg::CTRL_RESET;
      next_s.settle = SETTLE_LOAD;
      next_s.wph = fei_pkg::WP_COLLECT;
    end
  end

  always_ff @(posedge core_clk) begin
    s <= next_s;
  end

  assign phy_ctrl = s.ctrl;
  assign fall_event = s.event_q;
  assign fall_event_any = s.event_any;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_enable_after_reset: assert property (disable iff (1'b0)
    srst |=> s.en == fei_pkg::EN_RESET && s.settle == SETTLE_LOAD)
    else $error("Enable register not all ones after reset.");

  a_reserved_read_zero: assert property (
    rd_take && rd_sel != fei_pkg::SEL_STAT |=> s_axi_rvalid && s_axi_rdata[fei_pkg::DATA_W-1:fei_pkg::SIG_W] == '0)
    else $error("Reserved read bits not zero.");

  a_set_alias_write: assert property (
    wr_commit && wr_sel == fei_pkg::SEL_EN_SET && wr_strb0 |=> s.en == ($past(s.en) | $past(wr_data)) && s_axi_bvalid)
    else $error("Set alias did not OR into the enable register.");

  a_clear_alias_write: assert property (
    wr_commit && wr_sel == fei_pkg::SEL_EN_CLR && wr_strb0 |=> s.en == ($past(s.en) & ~$past(wr_data)))
    else $error("Clear alias did not clear the written ones.");

  a_alias_read_value: assert property (
    rd_take && rd_sel == fei_pkg::SEL_EN_SET |=> s_axi_rdata[fei_pkg::SIG_W-1:0] == $past(s.en) && s_axi_rresp == '0)
    else $error("Set alias read does not show the enable contents.");

  a_id_ground_event: assert property (
    fall[fei_pkg::SIG_ID_GROUND] && s.en[fei_pkg::SIG_ID_GROUND] && !id_mask
      |=> fall_event[fei_pkg::SIG_ID_GROUND] && fall_event_any)
    else $error("Enabled id-ground fall gave no event.");

  a_id_ground_masked: assert property (
    $rose(s.ctrl.id_pullup_ctrl) |-> s.settle == SETTLE_LOAD ##1 !fall_event[fei_pkg::SIG_ID_GROUND] [*8])
    else $error("Id-ground event leaked during the settling time.");

  a_session_end_event: assert property (
    ##1 fall_event[fei_pkg::SIG_SESS_END] == $past(fall[fei_pkg::SIG_SESS_END] && s.en[fei_pkg::SIG_SESS_END]))
    else $error("Session-end event does not follow its enabled edge.");

  a_session_valid_event: assert property (
    ##1 fall_event[fei_pkg::SIG_SESS_VALID] == $past(fall[fei_pkg::SIG_SESS_VALID] && s.en[fei_pkg::SIG_SESS_VALID]))
    else $error("Session-valid event does not follow its enabled edge.");

  a_vbus_ok_event: assert property (
    ##1 fall_event[fei_pkg::SIG_VBUS_OK] == $past(fall[fei_pkg::SIG_VBUS_OK] && s.en[fei_pkg::SIG_VBUS_OK]))
    else $error("Vbus-ok event does not follow its enabled edge.");

  a_host_disc_mode: assert property (
    fall_event[fei_pkg::SIG_HOST_DISC] |-> $past(host_mode) && $past(fall[fei_pkg::SIG_HOST_DISC]))
    else $error("Host-disconnect event outside host mode.");

  a_event_single_cycle: assert property (
    fall_event != '0 |=> (fall_event & $past(fall_event)) == '0)
    else $error("Event pulse lasted more than one cycle.");

  a_direct_write: assert property (
    wr_commit && wr_sel == fei_pkg::SEL_EN && wr_strb0 |=> s.en == $past(wr_data))
    else $error("Direct enable write did not land.");

  a_strobe_off_ignored: assert property (
    wr_commit && !wr_strb0 |=> s.en == $past(s.en) && s.ctrl == $past(s.ctrl))
    else $error("Write with byte strobe 0 changed a register.");

  a_bad_write_ignored: assert property (
    wr_commit && (wr_sel == fei_pkg::SEL_NONE || wr_sel == fei_pkg::SEL_STAT)
      |=> s.en == $past(s.en) && s.ctrl == $past(s.ctrl) && s_axi_bresp == fei_pkg::RESP_SLVERR)
    else $error("Refused write changed a register or was not refused.");

  a_reset_quiet: assert property (disable iff (1'b0)
    srst |=> fall_event == '0 && !fall_event_any && !s_axi_bvalid && !s_axi_rvalid)
    else $error("Outputs not quiet after reset.");

  a_clear_alias_read: assert property (
    rd_take && rd_sel == fei_pkg::SEL_EN_CLR |=> s_axi_rdata[fei_pkg::SIG_W-1:0] == $past(s.en))
    else $error("Clear alias read does not show the enable contents.");

  a_settle_reload: assert property (
    !s.ctrl.id_pullup_ctrl |=> s.settle == SETTLE_LOAD)
    else $error("Settling timer not reloaded while the pull-up is off.");

  a_settle_count: assert property (
    s.ctrl.id_pullup_ctrl && s.settle != '0 |=> s.settle == $past(s.settle) - 1'b1)
    else $error("Settling timer did not count down.");

  a_id_ground_off: assert property (
    !s.ctrl.id_pullup_ctrl |=> !fall_event[fei_pkg::SIG_ID_GROUND])
    else $error("Id-ground event while the pull-up is off.");

  a_host_disc_event: assert property (
    fall[fei_pkg::SIG_HOST_DISC] && s.en[fei_pkg::SIG_HOST_DISC] && host_mode
      |=> fall_event[fei_pkg::SIG_HOST_DISC])
    else $error("Enabled host-disconnect fall in host mode gave no event.");

  a_host_disc_blocked: assert property (
    !host_mode |=> !fall_event[fei_pkg::SIG_HOST_DISC])
    else $error("Host-disconnect event while not in host mode.");

  a_disabled_no_event: assert property (
    1'b1 |=> (fall_event & ~$past(s.en)) == '0)
    else $error("Event raised for a disabled signal.");

  a_event_from_edge: assert property (
    1'b1 |=> (fall_event & ~$past(fall)) == '0)
    else $error("Event raised without a detected falling edge.");

  a_any_matches: assert property (
    fall_event_any == (fall_event != '0))
    else $error("Summary event does not match the event bits.");

  c_set_alias: cover property (wr_commit && wr_sel == fei_pkg::SEL_EN_SET);
  c_clear_alias: cover property (wr_commit && wr_sel == fei_pkg::SEL_EN_CLR);
  c_id_event: cover property (fall_event[fei_pkg::SIG_ID_GROUND]);
  c_host_event: cover property (fall_event[fei_pkg::SIG_HOST_DISC]);
  c_masked_id_fall: cover property (fall[fei_pkg::SIG_ID_GROUND] && id_mask);

endmodule : fei_core

// *** bench/fei_phy_model.sv ***
// Behavioural model of the PHY that drives the status pins of the falling-edge event block.
// Assumes the bench sets the wanted pin levels and that the pins move just after a core_clk edge.
`timescale 1ns/1ns
module fei_phy_model (
  input wire logic core_clk,
  input wire logic [fei_pkg::SIG_W-1:0] want,
  output logic [fei_pkg::SIG_W-1:0] phy_status
);
  // The pins are always driven, so they never float between changes.
  always @(posedge core_clk) begin
    phy_status <= want;
  end
endmodule : fei_phy_model

// *** bench/falling_edge_int_enable_tb.sv ***
// Self-checking bench for the falling-edge event enable register and its event gating.
// Assumes fei_core as the device and fei_phy_model driving the PHY status pins.
`timescale 1ns/1ns
module falling_edge_int_enable_tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [1:0] s_axi_bresp;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic [4:0] phy_status;
  fei_pkg::fei_ctrl_type phy_ctrl;
  logic [4:0] fall_event;
  logic fall_event_any;
  logic [4:0] want = 5'h1f;
  int mismatches = 0;
  int num_checks = 0;

  always #2 core_clk = ~core_clk;

  fei_core #(.ID_SETTLE_CYCLES(20)) uut (
    .core_clk(core_clk), .srst(srst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .phy_status(phy_status),
    .phy_ctrl(phy_ctrl), .fall_event(fall_event), .fall_event_any(fall_event_any)
  );

  fei_phy_model phy (.core_clk(core_clk), .want(want), .phy_status(phy_status));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic bad(input string msg);
    mismatches++;
    $display("BAD %0t %s", $time, msg);
  endtask : bad

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad($sformatf("read data %h expected %h", got, exp));
    end
  endtask : chk_data

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad($sformatf("response %h expected %h", got, exp));
    end
  endtask : chk_resp

  task automatic chk_ev(input logic [4:0] got, input logic [4:0] exp, input int cnt, input int exp_cnt);
    num_checks++;
    if (got !== exp || cnt != exp_cnt) begin
      bad($sformatf("events %h in %0d cycles expected %h in %0d", got, cnt, exp, exp_cnt));
    end
  endtask : chk_ev

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk_resp(s_axi_bresp, exp);
  endtask : wr_chk

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp_d, input logic [1:0] exp_r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk_data(s_axi_rdata, exp_d);
    chk_resp(s_axi_rresp, exp_r);
  endtask : rd_chk

  // Drops every pin together, collects the pulses, then raises the pins and lets them settle.
  task automatic fall_and_watch(input logic [4:0] exp);
    logic [4:0] seen;
    int cnt;
    seen = 5'h00;
    cnt = 0;
    @(posedge core_clk);
    want <= 5'h00;
    repeat (12) begin
      @(posedge core_clk);
      seen = seen | fall_event;
      if (fall_event_any === 1'b1) begin
        cnt++;
      end
    end
    chk_ev(seen, exp, cnt, (exp != 5'h00) ? 1 : 0);
    want <= 5'h1f;
    repeat (8) @(posedge core_clk);
  endtask : fall_and_watch

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    rd_chk(fei_pkg::ADDR_EN, 32'h0000_001f, fei_pkg::RESP_OKAY);
    rd_chk(fei_pkg::ADDR_EN_SET, 32'h0000_001f, fei_pkg::RESP_OKAY);
    rd_chk(fei_pkg::ADDR_EN_CLR, 32'h0000_001f, fei_pkg::RESP_OKAY);
    wr_chk(fei_pkg::ADDR_EN, 32'hffff_ffe0, fei_pkg::RESP_OKAY);
    rd_chk(fei_pkg::ADDR_EN, 32'h0000_0000, fei_pkg::RESP_OKAY);
    wr_chk(fei_pkg::ADDR_EN_SET, 32'h0000_000a, fei_pkg::RESP_OKAY);
    wr_chk(fei_pkg::ADDR_EN_SET, 32'h0000_0005, fei_pkg::RESP_OKAY);
    rd_chk(fei_pkg::ADDR_EN_SET, 32'h0000_000f, fei_pkg::RESP_OKAY);
    wr_chk(fei_pkg::ADDR_EN_CLR, 32'h0000_0003, fei_pkg::RESP_OKAY);
    rd_chk(fei_pkg::ADDR_EN, 32'h0000_000c, fei_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'he;
    wr_chk(fei_pkg::ADDR_EN, 32'h0000_001f, fei_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd_chk(fei_pkg::ADDR_EN, 32'h0000_000c, fei_pkg::RESP_OKAY);
    wr_chk(8'hf0, 32'h0000_0001, fei_pkg::RESP_SLVERR);
    rd_chk(8'hf0, 32'h0000_0000, fei_pkg::RESP_SLVERR);
    wr_chk(fei_pkg::ADDR_STAT, 32'h0000_0001, fei_pkg::RESP_SLVERR);
    wr_chk(fei_pkg::ADDR_CTRL, 32'h0000_0007, fei_pkg::RESP_OKAY);
    repeat (30) @(posedge core_clk);
    chk_data(32'(phy_ctrl), 32'h0000_0007);
    rd_chk(fei_pkg::ADDR_CTRL, 32'h0000_0007, fei_pkg::RESP_OKAY);
    rd_chk(fei_pkg::ADDR_STAT, 32'h0000_021f, fei_pkg::RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      wr_chk(fei_pkg::ADDR_EN, 32'h0000_0001 << i, fei_pkg::RESP_OKAY);
      fall_and_watch(5'h01 << i);
    end
    wr_chk(fei_pkg::ADDR_EN, 32'h0000_0000, fei_pkg::RESP_OKAY);
    fall_and_watch(5'h00);
    wr_chk(fei_pkg::ADDR_EN_SET, 32'h0000_001f, fei_pkg::RESP_OKAY);
    wr_chk(fei_pkg::ADDR_CTRL, 32'h0000_0005, fei_pkg::RESP_OKAY);
    fall_and_watch(5'h1e);
    wr_chk(fei_pkg::ADDR_CTRL, 32'h0000_0006, fei_pkg::RESP_OKAY);
    fall_and_watch(5'h0f);
    wr_chk(fei_pkg::ADDR_CTRL, 32'h0000_0007, fei_pkg::RESP_OKAY);
    fall_and_watch(5'h0f);
    repeat (30) @(posedge core_clk);
    fall_and_watch(5'h1f);
    wr_chk(fei_pkg::ADDR_EN_CLR, 32'h0000_0015, fei_pkg::RESP_OKAY);
    rd_chk(fei_pkg::ADDR_EN, 32'h0000_000a, fei_pkg::RESP_OKAY);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rd_chk(fei_pkg::ADDR_EN, 32'h0000_001f, fei_pkg::RESP_OKAY);
    rd_chk(fei_pkg::ADDR_CTRL, 32'h0000_0000, fei_pkg::RESP_OKAY);
    chk_data(32'(phy_ctrl), 32'h0000_0000);
    wrap_up();
  end

  // The whole sequence takes well under 2000 cycles.
  initial begin
    repeat (20000) @(posedge core_clk);
    bad("watchdog expired");
    wrap_up();
  end
endmodule : falling_edge_int_enable_tb
